// file: rtl/dbp_pkg.sv
// Overview of operation
// - Only a hardware debug command may change the debug clock switch bit.
// - Pll select 0 gives oscillator bus clock; 1 with switch 0 alternate.
// - Alternate clock selected: link logic fully synchronized to that clock.
// - Acknowledge of the switch-changing write already runs at the new rate.
// - In emulation modes the clock switch bit leaves reset set to one.
// - Secured: unsecure flag written only in special single chip by firmware.
// - Entering secure mode clears the flag and maps the secure lookup table.
// - Erase check passed: flag set, jump to standard table, secure table off.
// - Unsecure flag reads 0 while secured and 1 while unsecured.
// - Flag set: flash security bits changeable; else secured at next reset.
// - Security byte unsecured: the flag has no meaning or effect after reset.
package dbp_pkg;

  // ******************************************************************
  // register map
  // ******************************************************************
  localparam logic [7:0] OFS_DBG_CTRL      = 8'h00;
  localparam int         BIT_CLOCK_SWITCH  = 2;
  localparam int         BIT_UNSECURE      = 1;
  localparam int         BIT_SETTLE        = 0;
  localparam logic [7:0] RST_RDATA         = 8'h00;

  // ******************************************************************
  // link timing, counted in link clock ticks
  // ******************************************************************
  localparam int         SETTLE_CYCLES     = 150;
  localparam int         ACK_CYCLES        = 16;
  localparam int         TIMER_W           = 8;

  // ******************************************************************
  // debug link clock sources
  // ******************************************************************
  typedef enum logic [1:0] {
    SEL_OSC_BUS,
    SEL_ALT,
    SEL_PLL_BUS
  } dbp_link_sel_e;

endpackage

// file: rtl/dbp_edge_sync.sv
`timescale 1ns/1ps
module dbp_edge_sync (
  // clock and reset
  input  wire logic CLOCK,
  input  wire logic ARST_N,
  // asynchronous level in, rising edge pulse out
  input  wire logic async_in,
  output logic      rise
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } dbp_sync_s;

  dbp_sync_s st;
  dbp_sync_s next_st;

  // ******************************************************************
  // two stage synchronizer plus edge history
  // ******************************************************************
  always_comb begin
    next_st      = st;
    next_st.meta = async_in;
    next_st.sync = st.meta;
    next_st.last = st.sync;
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = st.sync & ~st.last;

endmodule

// file: rtl/dbp_tick_timer.sv
`timescale 1ns/1ps
module dbp_tick_timer #(
  parameter int LEN = 16,
  parameter int W   = 8
) (
  // clock and reset
  input  wire logic CLOCK,
  input  wire logic ARST_N,
  // control
  input  wire logic start,
  input  wire logic tick,
  // status
  output logic      busy
);

  localparam logic [W-1:0] LOAD = W'(LEN);
  localparam logic [W-1:0] ONE  = W'(1);

  typedef struct packed {
    logic [W-1:0] count;
  } dbp_timer_s;

  dbp_timer_s st;
  dbp_timer_s next_st;

  // ******************************************************************
  // runs for LEN ticks after the last start
  // ******************************************************************
  always_comb begin
    next_st = st;
    if (start) begin
      next_st.count = LOAD;
    end else if (tick && st.count != '0) begin
      next_st.count = st.count - ONE;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = (st.count != '0);

endmodule

// file: rtl/dbp_debug_port.sv
`timescale 1ns/1ps
module dbp_debug_port
  import dbp_pkg::*;
(
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       ARST_N,
  // register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // hardware debug command
  input  wire logic       CMD_WR,
  input  wire logic       CMD_CLOCK_SWITCH,
  input  wire logic       CMD_ACK_EN,
  // modes and straps
  input  wire logic       PLL_SELECT,
  input  wire logic       ALT_CLOCK_PIN,
  input  wire logic       EMULATION_MODE,
  input  wire logic       SPECIAL_SINGLE_CHIP,
  input  wire logic       SECURE_FW_ACTIVE,
  input  wire logic       SEC_BYTE_SECURED,
  // secure firmware erase check
  input  wire logic       ERASE_DONE,
  input  wire logic       ERASE_PASS,
  // debug link timing
  output logic      [1:0] LINK_CLOCK_SELECT,
  output logic            LINK_TICK,
  output logic            LINK_ACK,
  output logic            SETTLE_BUSY,
  // security
  output logic            DEVICE_SECURED,
  output logic            SECURE_TABLE_EN,
  output logic            JUMP_STANDARD,
  output logic            FLASH_SEC_CHANGE_EN
);

  // ******************************************************************
  // state
  // ******************************************************************
  typedef struct packed {
    logic          init_done;
    logic          strap_secure;
    logic          clock_switch;
    logic          unsecure_flag;
    logic          secure_table;
    logic          jump_standard;
    logic [7:0]    rdata;
    dbp_link_sel_e sel;
  } dbp_core_s;

  localparam dbp_core_s ST_RESET = '{
    init_done:     1'b0,
    strap_secure:  1'b1,
    clock_switch:  1'b0,
    unsecure_flag: 1'b0,
    secure_table:  1'b0,
    jump_standard: 1'b0,
    rdata:         RST_RDATA,
    sel:           SEL_OSC_BUS
  };

  dbp_core_s st;
  dbp_core_s next_st;

  logic ctrl_wr;
  logic ctrl_rd;
  logic secured;
  logic unsecure_flag_wr_ok;
  logic erase_ok;
  logic alt_rise;
  logic link_tick;
  logic settle_start;
  logic ack_start;
  logic settle_busy;
  logic ack_busy;

  // ******************************************************************
  // clock source mapping
  // ******************************************************************
  function automatic dbp_link_sel_e sel_map(input logic pll,
                                            input logic sw);
    dbp_link_sel_e s;
    s = SEL_OSC_BUS;
    if (pll && !sw) begin
      s = SEL_ALT;
    end else if (pll && sw) begin
      s = SEL_PLL_BUS;
    end
    return s;
  endfunction

  // ******************************************************************
  // decode and qualifiers
  // ******************************************************************
  assign ctrl_wr     = REG_WR && (REG_ADDR == OFS_DBG_CTRL);
  assign ctrl_rd     = REG_RD && (REG_ADDR == OFS_DBG_CTRL);
  // unsecured security byte makes the flag meaningless
  assign secured     = st.strap_secure & ~st.unsecure_flag;
  assign unsecure_flag_wr_ok = ~secured | (SPECIAL_SINGLE_CHIP & SECURE_FW_ACTIVE);
  assign erase_ok    = ERASE_DONE & ERASE_PASS & st.secure_table;

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb begin
    next_st               = st;
    next_st.rdata         = RST_RDATA;
    next_st.jump_standard = 1'b0;
    if (!st.init_done) begin
      // straps caught in the first cycle after reset release
      next_st.init_done     = 1'b1;
      next_st.strap_secure  = SEC_BYTE_SECURED;
      next_st.clock_switch  = EMULATION_MODE;
      next_st.unsecure_flag = 1'b0;
      next_st.secure_table  = SEC_BYTE_SECURED;
    end else begin
      // register port never touches the switch
      if (CMD_WR) begin
        next_st.clock_switch = CMD_CLOCK_SWITCH;
      end
      if (ctrl_wr && unsecure_flag_wr_ok) begin
        next_st.unsecure_flag = REG_WDATA[BIT_UNSECURE];
      end
      // erase pass wins over a same cycle clearing write
      if (erase_ok) begin
        next_st.unsecure_flag = 1'b1;
        next_st.secure_table  = 1'b0;
        next_st.jump_standard = 1'b1;
      end
    end
    // mapping follows pll select with no software step
    next_st.sel = sel_map(PLL_SELECT, next_st.clock_switch);
    if (ctrl_rd) begin
      next_st.rdata[BIT_CLOCK_SWITCH] = st.clock_switch;
      next_st.rdata[BIT_UNSECURE]     = ~secured;
      next_st.rdata[BIT_SETTLE]       = settle_busy;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ******************************************************************
  // link timing
  // ******************************************************************
  dbp_edge_sync u_alt_sync (
    .CLOCK    (CLOCK),
    .ARST_N   (ARST_N),
    .async_in (ALT_CLOCK_PIN),
    .rise     (alt_rise)
  );

  // with the alternate source selected, its edges alone time the link; bus sources tick every cycle
  assign link_tick    = (st.sel == SEL_ALT) ? alt_rise : 1'b1;
  // any change of effective source
  assign settle_start = st.init_done && (next_st.sel != st.sel);
  // timer loads with the switch update, so it counts new ticks
  assign ack_start    = st.init_done && CMD_WR && CMD_ACK_EN;

  dbp_tick_timer #(
    .LEN (SETTLE_CYCLES),
    .W   (TIMER_W)
  ) u_settle (
    .CLOCK  (CLOCK),
    .ARST_N (ARST_N),
    .start  (settle_start),
    .tick   (link_tick),
    .busy   (settle_busy)
  );

  dbp_tick_timer #(
    .LEN (ACK_CYCLES),
    .W   (TIMER_W)
  ) u_ack (
    .CLOCK  (CLOCK),
    .ARST_N (ARST_N),
    .start  (ack_start),
    .tick   (link_tick),
    .busy   (ack_busy)
  );

  // ******************************************************************
  // outputs
  // ******************************************************************
  assign REG_RDATA           = st.rdata;
  assign LINK_CLOCK_SELECT   = st.sel;
  assign LINK_TICK           = link_tick;
  assign LINK_ACK            = ack_busy;
  assign SETTLE_BUSY         = settle_busy;
  assign DEVICE_SECURED      = secured;
  assign SECURE_TABLE_EN     = st.secure_table;
  assign JUMP_STANDARD       = st.jump_standard;
  assign FLASH_SEC_CHANGE_EN = st.init_done & ~secured;

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);

  a_switch_sw_only: assert property (
    (st.init_done && !CMD_WR) |=> $stable(st.clock_switch))
    else $error("clock switch moved without a debug command");

  a_switch_cmd: assert property (
    (st.init_done && CMD_WR) |=> (st.clock_switch == $past(CMD_CLOCK_SWITCH)))
    else $error("debug command did not set clock switch");

  a_select_map: assert property (
    st.init_done |=>
      (st.sel == sel_map($past(PLL_SELECT), st.clock_switch)))
    else $error("link clock select does not follow mapping");

  a_alt_tick: assert property (
    (st.sel == SEL_ALT && LINK_TICK) |-> alt_rise)
    else $error("alternate link tick without alternate edge");

  a_ack_rate: assert property (
    ack_start |=> LINK_ACK [*8])
    else $error("acknowledge did not start after command");

  a_settle_busy: assert property (
    settle_start |=> SETTLE_BUSY [*8])
    else $error("settle window missing after source change");

  a_settle_bus: assert property (
    (settle_start && next_st.sel != SEL_ALT && !PLL_SELECT ##1
     !settle_start [*8]) |-> SETTLE_BUSY)
    else $error("settle window too short on bus clock");

  a_emul_reset: assert property (
    $rose(st.init_done) |-> (st.clock_switch == $past(EMULATION_MODE)))
    else $error("clock switch reset value ignores emulation mode");

  a_unsecure_flag_guard: assert property (
    (st.init_done && secured && !unsecure_flag_wr_ok && !erase_ok)
      |=> !st.unsecure_flag)
    else $error("secured flag changed by a forbidden write");

  a_secure_entry: assert property (
    ($rose(st.init_done) && st.strap_secure)
      |-> (!st.unsecure_flag && st.secure_table))
    else $error("secure entry did not clear flag and map table");

  a_erase_pass: assert property (
    (st.init_done && erase_ok)
      |=> (st.unsecure_flag && !st.secure_table && JUMP_STANDARD))
    else $error("erase pass did not unsecure the device");

  a_erase_fail: assert property (
    (st.init_done && ERASE_DONE && !ERASE_PASS && secured && !unsecure_flag_wr_ok)
      |=> !st.unsecure_flag)
    else $error("failed erase check set the unsecure flag");

  a_read_flag: assert property (
    ctrl_rd |=> (REG_RDATA[BIT_UNSECURE] == !$past(secured)))
    else $error("unsecure flag read value wrong");

  a_flash_enable: assert property (
    (st.init_done && st.unsecure_flag) |-> FLASH_SEC_CHANGE_EN)
    else $error("flash security not changeable while unsecured");

  a_flag_moot: assert property (
    (st.init_done && !st.strap_secure) |-> !DEVICE_SECURED)
    else $error("flag affects security with unsecured byte");

  a_alt_sync_path: assert property (
    (st.sel == SEL_ALT && LINK_TICK) |-> $past(ALT_CLOCK_PIN, 2))
    else $error("alternate tick without a synchronized pin level");

  a_bus_tick: assert property (
    (st.sel != SEL_ALT) |-> LINK_TICK)
    else $error("bus clock source missed a link tick");

  a_rdata_idle: assert property (
    !ctrl_rd |=> (REG_RDATA == RST_RDATA))
    else $error("read data showing outside the read answer cycle");

  a_read_switch: assert property (
    ctrl_rd |=> (REG_RDATA[BIT_CLOCK_SWITCH] == $past(st.clock_switch)))
    else $error("clock switch read value wrong");

  a_jump_pulse: assert property (
    JUMP_STANDARD |=> !JUMP_STANDARD)
    else $error("jump to standard table longer than one cycle");

  a_table_off: assert property (
    (st.init_done && !st.secure_table) |=> !st.secure_table)
    else $error("secure table came back without a reset");

  a_flash_locked: assert property (
    (st.init_done && DEVICE_SECURED) |-> !FLASH_SEC_CHANGE_EN)
    else $error("flash security changeable while secured");

endmodule

// file: tb/dbp_host_model.sv
`timescale 1ns/1ps
module dbp_host_model (
  // clock
  input  wire logic clock,
  // link status from the port
  input  wire logic settle_busy,
  // command lines
  output logic      cmd_wr,
  output logic      cmd_clock_switch,
  output logic      cmd_ack_en
);
  initial begin
    cmd_wr = 1'b0;
    cmd_clock_switch = 1'b0;
    cmd_ack_en = 1'b0;
  end

  // one command, held off while the link clock settles
  task automatic send(input logic sw, input logic ack);
    int i;
    @(negedge clock);
    for (i = 0; i < 2000 && settle_busy !== 1'b0; i++) begin
      @(negedge clock);
    end
    @(posedge clock);
    cmd_wr           <= 1'b1;
    cmd_clock_switch <= sw;
    cmd_ack_en       <= ack;
    @(posedge clock);
    cmd_wr           <= 1'b0;
    cmd_clock_switch <= ~sw;
  endtask
endmodule

// file: tb/dbp_debug_port_tb_top.sv
`timescale 1ns/1ps
module dbp_debug_port_tb_top;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic       clock = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       pll_sel = 1'b0, alt_pin = 1'b0, emu = 1'b0, ssc = 1'b0;
  logic       fw = 1'b0, sec_byte = 1'b1, e_done = 1'b0, e_pass = 1'b0;
  logic       cmd_wr, cmd_sw, cmd_ack, link_tick, link_ack, settle;
  logic       secured, table_en, jump, flash_en;
  logic [1:0] link_sel;
  logic [1:0] alt_cnt = 2'h0;
  int         n_errors = 0;
  int         compares = 0;

  // ********
  // clocks and instances
  // ********
  initial begin
    forever begin
      #2.5 clock = ~clock;
    end
  end

  // alternate clock, period of six bus cycles
  always @(posedge clock) begin
    alt_cnt <= (alt_cnt == 2'h2) ? 2'h0 : alt_cnt + 2'h1;
    if (alt_cnt == 2'h2) alt_pin <= ~alt_pin;
  end

  dbp_host_model i_host (.clock(clock), .settle_busy(settle),
    .cmd_wr(cmd_wr), .cmd_clock_switch(cmd_sw), .cmd_ack_en(cmd_ack));

  dbp_debug_port i_dut (.CLOCK(clock), .ARST_N(arst_n),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CMD_WR(cmd_wr),
    .CMD_CLOCK_SWITCH(cmd_sw), .CMD_ACK_EN(cmd_ack),
    .PLL_SELECT(pll_sel), .ALT_CLOCK_PIN(alt_pin), .EMULATION_MODE(emu),
    .SPECIAL_SINGLE_CHIP(ssc), .SECURE_FW_ACTIVE(fw),
    .SEC_BYTE_SECURED(sec_byte), .ERASE_DONE(e_done),
    .ERASE_PASS(e_pass), .LINK_CLOCK_SELECT(link_sel),
    .LINK_TICK(link_tick), .LINK_ACK(link_ack), .SETTLE_BUSY(settle),
    .DEVICE_SECURED(secured), .SECURE_TABLE_EN(table_en),
    .JUMP_STANDARD(jump), .FLASH_SEC_CHANGE_EN(flash_en));

  // ********
  // shared tasks
  // ********
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // status bits: secured, table, jump, flash change
  task automatic st(input logic [7:0] e);
    #1;
    chk("status", e, {4'h0, secured, table_en, jump, flash_en});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask

  task automatic do_reset(input logic em, input logic sb);
    arst_n   <= 1'b0;
    emu      <= em;
    sec_byte <= sb;
    pll_sel  <= 1'b0;
    repeat (8) @(posedge clock);
    arst_n   <= 1'b1;
    repeat (2) @(posedge clock);
  endtask

  task automatic erase(input logic p);
    @(posedge clock);
    e_done <= 1'b1;
    e_pass <= p;
    @(posedge clock);
    e_done <= 1'b0;
    e_pass <= ~p;
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_reset_state;
    st(8'h0c);
    rdx(8'h00, 8'h00);
    $display("t_reset_state done");
  endtask

  task automatic t_clock_select;
    logic [4:0] pl = 5'h0e;
    logic [4:0] sw = 5'h1b;
    logic [1:0] ex [5] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h0};
    logic [7:0] n;
    for (int i = 0; i < 5; i++) begin
      // quiet link first, so settle seen below belongs to this step
      for (int k = 0; k < 2000 && settle !== 1'b0; k++) begin
        @(posedge clock);
        #1;
      end
      @(posedge clock);
      pll_sel <= pl[i];
      @(posedge clock);
      #1;
      if (i == 1 || i == 4) chk("settle", 8'h01, {7'h0, settle});
      if (i == 1) begin
        repeat (149) @(posedge clock);
        #1;
        chk("settle_last", 8'h01, {7'h0, settle});
        @(posedge clock);
        #1;
        chk("settle_end", 8'h00, {7'h0, settle});
      end
      i_host.send(sw[i], 1'b1);
      #1;
      chk("select", {6'h0, ex[i]}, {6'h0, link_sel});
      chk("ack", 8'h01, {7'h0, link_ack});
      if (i == 2) begin
        n = 8'h00;
        repeat (60) begin
          @(posedge clock);
          #1;
          n = n + {7'h0, link_tick};
        end
        chk("ticks", 8'h0a, n);
      end
      if (i == 3) begin
        repeat (15) @(posedge clock);
        #1;
        chk("ack_last", 8'h01, {7'h0, link_ack});
        @(posedge clock);
        #1;
        chk("ack_end", 8'h00, {7'h0, link_ack});
      end
    end
    $display("t_clock_select done");
  endtask

  task automatic t_reg_guard;
    wr(8'h00, 8'h00);
    rdx(8'h00, 8'h04);
    rdx(8'h05, 8'h00);
    $display("t_reg_guard done");
  endtask

  task automatic t_unsecure_write;
    wr(8'h00, 8'h02);
    rdx(8'h00, 8'h04);
    @(posedge clock);
    ssc <= 1'b1;
    wr(8'h00, 8'h02);
    rdx(8'h00, 8'h04);
    @(posedge clock);
    fw <= 1'b1;
    wr(8'h00, 8'h02);
    rdx(8'h00, 8'h06);
    wr(8'h00, 8'h00);
    rdx(8'h00, 8'h04);
    @(posedge clock);
    ssc <= 1'b0;
    fw  <= 1'b0;
    $display("t_unsecure_write done");
  endtask

  task automatic t_erase;
    erase(1'b0);
    st(8'h0c);
    erase(1'b1);
    st(8'h03);
    @(posedge clock);
    st(8'h01);
    rdx(8'h00, 8'h02);
    $display("t_erase done");
  endtask

  task automatic t_reset_straps;
    do_reset(1'b1, 1'b1);
    st(8'h0c);
    rdx(8'h00, 8'h04);
    do_reset(1'b0, 1'b0);
    st(8'h01);
    rdx(8'h00, 8'h02);
    wr(8'h00, 8'h00);
    st(8'h01);
    $display("t_reset_straps done");
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    do_reset(1'b0, 1'b1);
    t_reset_state();
    t_clock_select();
    t_reg_guard();
    t_unsecure_write();
    do_reset(1'b0, 1'b1);
    t_erase();
    t_reset_straps();
    end_of_test();
  end
endmodule
